// ---- tb_transfer_skip_instr_exec.sv ----
`timescale 1ns/10ps
`default_nettype none

// ====================================================================
// bench: apb master plus instruction sequences
module tb_transfer_skip_instr_exec;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [31:0] pwdata_in = 32'h0;
  logic [5:0] port_in = 6'h2A;
  wire [31:0] prdata_out;
  wire pready_out;
  wire pslverr_out;
  wire busy_out;
  wire [7:0] timer_one_out;
  wire [7:0] timer_two_out;
  integer n_fail = 0;
  integer num_checks = 0;
  integer y;
  logic [31:0] rd_v;
  logic err_v;
  logic [9:0] ops [4] = '{10'h253, 10'h256, 10'h259, 10'h25A};

  always #2.5 clk_in = ~clk_in;

  tsie_core dut (.clk_in, .nrst_in, .paddr_in, .psel_in, .penable_in,
    .pwrite_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .port_in, .timer_one_out, .timer_two_out, .busy_out);

  // ==================================================================
  // reporting
  task summarize;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      num_checks++;
      if (g !== e) begin
        n_fail++;
        $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
    end
  endtask

  // ==================================================================
  // apb transfer; one idle edge first so no signal is set twice
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer i;
    begin
      @(posedge clk_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      i = 0;
      do begin
        @(posedge clk_in);
        i++;
      end while (pready_out !== 1'b1 && i < 20);
      if (pready_out !== 1'b1) begin
        n_fail++;
        summarize;
      end
      rd_v = prdata_out;
      err_v = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
    end
  endtask

  task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
    input string nm);
    begin
      bus(1'b0, a, 32'h0);
      chk(nm, e, rd_v & m);
    end
  endtask

  // issue one word, then wait for the executor to go idle
  task ex(input logic [9:0] op);
    integer i;
    begin
      bus(1'b1, 8'h00, {22'h0, op});
      @(posedge clk_in);
      i = 0;
      do begin
        @(posedge clk_in);
        i++;
      end while (busy_out !== 1'b0 && i < 40);
      if (busy_out !== 1'b0) begin
        n_fail++;
        summarize;
      end
    end
  endtask

  // ==================================================================
  // main sequence
  initial begin
    repeat (16) @(posedge clk_in);
    nrst_in <= 1'b1;
    rc(8'h24, 32'h70FFF, 32'h70000, "pcsp");
    bus(1'b0, 8'h30, 32'h0);
    chk("slverr", 32'h1, {31'h0, err_v});
    $display("test reset done");
    bus(1'b1, 8'h04, 32'h1A5);
    ex(10'h01E);
    rc(8'h04, 32'h1FF, 32'h1AA, "b_to_a");
    bus(1'b1, 8'h04, 32'h03C);
    ex(10'h230);
    rc(8'h10, 32'hFFFF, 32'h3C3C, "tmr1");
    chk("t1out", 32'h3C, {24'h0, timer_one_out});
    bus(1'b1, 8'h04, 32'h0D2);
    ex(10'h231);
    rc(8'h14, 32'hFFFF, 32'hD2D2, "tmr2");
    chk("t2out", 32'hD2, {24'h0, timer_two_out});
    bus(1'b1, 8'h10, 32'h0A7);
    ex(10'h270);
    rc(8'h04, 32'hFF, 32'hA7, "rd_t1");
    bus(1'b1, 8'h14, 32'h05B);
    ex(10'h271);
    rc(8'h04, 32'hFF, 32'h5B, "rd_t2");
    $display("test timers done");
    bus(1'b1, 8'h18, 32'h2B6);
    ex(10'h279);
    rc(8'h04, 32'hFF, 32'hAD, "conv");
    bus(1'b1, 8'h18, 32'h10000);
    bus(1'b1, 8'h04, 32'h0C3);
    ex(10'h239);
    rc(8'h1C, 32'hFF, 32'hC3, "cmp_wr");
    bus(1'b1, 8'h04, 32'h0);
    ex(10'h279);
    rc(8'h04, 32'hFF, 32'hC3, "cmp_rd");
    bus(1'b1, 8'h18, 32'h003);
    bus(1'b1, 8'h04, 32'h011);
    ex(10'h239);
    rc(8'h1C, 32'hFF, 32'hC3, "cmp_nop");
    bus(1'b1, 8'h04, 32'h0F5);
    ex(10'h249);
    rc(8'h04, 32'hFF, 32'hFC, "low");
    $display("test conversion done");
    bus(1'b1, 8'h0C, 32'h96);
    ex(10'h02A);
    rc(8'h04, 32'hFF, 32'h96, "rd_e");
    rc(8'h0C, 32'hFF, 32'h96, "e_kept");
    bus(1'b1, 8'h08, 32'h70);
    bus(1'b1, 8'h04, 32'hFF);
    ex(10'h051);
    rc(8'h04, 32'hFF, 32'hF7, "rd_d");
    bus(1'b1, 8'h20, 32'h4321);
    for (y = 0; y < 4; y++) begin
      bus(1'b1, 8'h04, 32'h0);
      ex(ops[y]);
      rc(8'h04, 32'hF, y + 1, "ctl");
    end
    $display("test transfers done");
    bus(1'b1, 8'h04, 32'h050);
    ex(10'h02F);
    rc(8'h00, 32'h2, 32'h2, "skip_c0");
    ex(10'h01E);
    rc(8'h04, 32'h1FF, 32'h050, "skipped");
    bus(1'b1, 8'h04, 32'h150);
    ex(10'h02F);
    rc(8'h00, 32'h2, 32'h0, "skip_c1");
    ex(10'h01E);
    rc(8'h04, 32'h1FF, 32'h155, "run_c1");
    // port bits 1, 3, 5 high; y 6 and 7 must never skip
    for (y = 0; y < 8; y++) begin
      bus(1'b1, 8'h08, y);
      bus(1'b1, 8'h24, 32'h0);
      ex(10'h024);
      rc(8'h00, 32'h2, (y < 6 && !port_in[y]) ? 2 : 0, "skip_p");
      if (y < 6)
        rc(8'h24, 32'hFFF, 32'h2, "pc_two");
      ex(10'h000);
    end
    $display("test skips done");
    bus(1'b1, 8'h28, 32'h1D9);
    bus(1'b1, 8'h2C, 32'h3A5);
    bus(1'b1, 8'h08, 32'h050);
    bus(1'b1, 8'h04, 32'h009);
    bus(1'b1, 8'h24, 32'h100);
    ex(10'h083);
    rc(8'h04, 32'hFF, 32'hA5, "table");
    rc(8'h24, 32'h70FFF, 32'h70101, "stack");
    $display("test table done");
    summarize;
  end
endmodule

bind tsie_core tsie_chk chk (.clk_in, .nrst_in, .paddr_in, .psel_in,
  .penable_in, .pwrite_in, .pwdata_in, .prdata_out, .pready_out,
  .pslverr_out, .port_in, .timer_one_out, .timer_two_out, .busy_out);

`default_nettype wire

// ---- tsie_chk_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none

// ====================================================================
// port-level checks for the instruction executor
module tsie_chk (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // apb
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // core
  input wire logic [5:0] port_in,
  input wire logic [7:0] timer_one_out,
  input wire logic [7:0] timer_two_out,
  input wire logic busy_out
);
  logic go;
  logic [4:0] cnt_ff;
  logic [4:0] len_ff;
  assign go = psel_in & penable_in & pready_out & pwrite_in & ~busy_out
    & (paddr_in[7:2] == 6'h00);
  // busy edges per word: four clocks per cycle plus the commit edge
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_ff <= 5'h00;
      len_ff <= 5'h00;
    end else begin
      if (go) begin
        len_ff <= (pwdata_in[9:5] == 5'h04) ? 5'h0D :
          (pwdata_in[9:0] == 10'h024) ? 5'h09 : 5'h05;
      end
      cnt_ff <= busy_out ? cnt_ff + 5'h01 : 5'h00;
    end
  end
  ready_pulse_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    pready_out |=> !pready_out) else $error("ready held too long");
  one_wait_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $rose(penable_in) && psel_in |-> !pready_out ##1 pready_out)
    else $error("wait state count wrong");
  err_ready_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    pslverr_out |-> pready_out) else $error("error without ready");
  err_data_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    pslverr_out |-> prdata_out == 32'h0) else $error("error data not zero");
  busy_start_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    go |=> busy_out) else $error("issue did not start");
  busy_cause_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $rose(busy_out) |-> $past(go)) else $error("busy without issue");
  busy_len_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $fell(busy_out) && len_ff != 5'h00 |-> cnt_ff == len_ff)
    else $error("instruction length wrong");
  timer_hold_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !$stable({timer_one_out, timer_two_out}) |-> $fell(busy_out) ||
    $past(psel_in & penable_in & pready_out & pwrite_in &
    (paddr_in[7:3] == 5'h02))) else $error("timer changed unasked");
endmodule

`default_nettype wire

// ---- tsie_core.v ----
// Summary of operation
// RULE_01: skip next when carry clear; carry kept
// RULE_02: port-bit skip: two words, two cycles
// RULE_03: Y 0..5 picks port bit; else nop
// RULE_04: timer one and reload get B:A
// RULE_05: timer two and reload get B:A
// RULE_06: B copied to A, one cycle
// RULE_07: timer count high to B, low to A
// RULE_08: conversion read depends on comparator mode
// RULE_09: comparator write only in comparator mode
// RULE_10: extended register split into B and A
// RULE_11: table read, three cycles, ROM to B:A
// RULE_12: table read uses one stack level
// RULE_13: port select to A, bit three zero
// RULE_14: interrupt control one copied to A
// RULE_15: wakeup control registers copied to A
// RULE_16: result low bits to A high bits
// RULE_17: skipped instruction burns cycles, changes nothing
`include "tsie_defs.vh"
`timescale 1ns/10ps
`default_nettype none

module tsie_core (
  // clock and reset
  input wire clk_in,
  input wire nrst_in,
  // apb slave
  input wire [7:0] paddr_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  // port pins
  input wire [5:0] port_in,
  // state view
  output reg [7:0] timer_one_out,
  output reg [7:0] timer_two_out,
  output reg busy_out
);

  // ==================================================================
  // state
  reg [3:0] a_ff, b_ff, y_ff, i1_ff, k0_ff, k1_ff, k2_ff;
  reg cy_ff, q13_ff, skip_ff, run_skip_ff;
  reg [2:0] d_ff, sp_ff;
  reg [7:0] e_ff, r1_ff, r2_ff, cmp_ff;
  reg [9:0] adres_ff, op_ff, romq_ff;
  reg [11:0] pc_ff, roma_ff;
  reg [1:0] cnt_ff;
  reg [9:0] rom_mem [0:4095];
  reg [11:0] stk_mem [0:7];

  wire tick;
  wire acc_ph = psel_in & penable_in;
  wire wr_go = acc_ph & pready_out & pwrite_in;
  wire [7:0] ofs = {paddr_in[7:2], 2'b00};
  wire is_table = (op_ff[9:5] == `TSIE_OP_TABLE_HI);
  wire [11:0] tbl_addr = {op_ff[4:0], d_ff, a_ff};
  wire last_cyc = tick & busy_out & (cnt_ff == 2'd1);
  wire live = ~run_skip_ff;
  wire start = wr_go & (ofs == `TSIE_OFS_EXEC) & ~busy_out;

  // ==================================================================
  // cycle length per instruction word
  reg [1:0] ncyc;
  reg [1:0] nwords;
  always @* begin
    ncyc = 2'd1;
    nwords = 2'd1;
    if (pwdata_in[9:0] == `TSIE_OP_SKIP_PORT) begin
      ncyc = 2'd2; // [RULE_02]
      nwords = 2'd2;
    end else if (pwdata_in[9:5] == `TSIE_OP_TABLE_HI) begin
      ncyc = 2'd3; // [RULE_11]
    end
  end

  reg [1:0] op_words;
  always @* begin
    op_words = (op_ff == `TSIE_OP_SKIP_PORT) ? 2'd2 : 2'd1;
  end

  // ==================================================================
  // skip decision made at end of a live instruction
  reg skip_new;
  always @* begin
    skip_new = 1'b0;
    if (op_ff == `TSIE_OP_SKIP_CARRY) begin
      skip_new = ~cy_ff; // [RULE_01]
    end else if (op_ff == `TSIE_OP_SKIP_PORT) begin
      // out of range selector acts as nop
      if (y_ff < `TSIE_PORT_BITS) begin
        skip_new = ~port_in[y_ff[2:0]]; // [RULE_03]
      end
    end
  end

  tsie_cyc_div #(
    .DIV(`TSIE_CYC_CLKS)
  ) u_div (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .run_in(busy_out),
    .tick_out(tick)
  );

  // ==================================================================
  // memories: rom loaded over apb, stack written by table read
  always @(posedge clk_in) begin
    if (wr_go && ofs == `TSIE_OFS_ROMD) begin
      rom_mem[roma_ff] <= pwdata_in[9:0];
    end
    if (tick && busy_out && live && is_table && cnt_ff == 2'd3) begin
      stk_mem[sp_ff + 3'd1] <= pc_ff; // [RULE_12]
    end
  end

  // ==================================================================
  // apb answer: one wait state, data registered with pready
  reg [31:0] rd_mux;
  reg rd_err;
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    case (ofs)
      `TSIE_OFS_EXEC: rd_mux = {30'h0, skip_ff, busy_out};
      `TSIE_OFS_ACC: rd_mux = {23'h0, cy_ff, b_ff, a_ff};
      `TSIE_OFS_YD: rd_mux = {25'h0, d_ff, y_ff};
      `TSIE_OFS_EXT: rd_mux = {24'h0, e_ff};
      `TSIE_OFS_TMR1: rd_mux = {16'h0, r1_ff, timer_one_out};
      `TSIE_OFS_TMR2: rd_mux = {16'h0, r2_ff, timer_two_out};
      `TSIE_OFS_ADC: rd_mux = {15'h0, q13_ff, 6'h0, adres_ff};
      `TSIE_OFS_CMP: rd_mux = {24'h0, cmp_ff};
      `TSIE_OFS_CTL: rd_mux = {16'h0, k2_ff, k1_ff, k0_ff, i1_ff};
      `TSIE_OFS_PCSP: rd_mux = {13'h0, sp_ff, 4'h0, pc_ff};
      `TSIE_OFS_ROMA: rd_mux = {20'h0, roma_ff};
      `TSIE_OFS_ROMD: rd_mux = {22'h0, rom_mem[roma_ff]};
      default: rd_err = 1'b1;
    endcase
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pready_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= acc_ph & ~pready_out;
      if (acc_ph && !pready_out) begin
        prdata_out <= pwrite_in ? 32'h0000_0000 : rd_mux;
        pslverr_out <= rd_err;
      end else begin
        pslverr_out <= 1'b0;
      end
    end
  end

  // ==================================================================
  // register writes from software, then instruction effects
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      a_ff <= `TSIE_RST_NIB;
      b_ff <= `TSIE_RST_NIB;
      y_ff <= `TSIE_RST_NIB;
      i1_ff <= `TSIE_RST_NIB;
      k0_ff <= `TSIE_RST_NIB;
      k1_ff <= `TSIE_RST_NIB;
      k2_ff <= `TSIE_RST_NIB;
      cy_ff <= 1'b0;
      q13_ff <= 1'b0;
      d_ff <= 3'h0;
      e_ff <= `TSIE_RST_BYTE;
      timer_one_out <= `TSIE_RST_BYTE;
      timer_two_out <= `TSIE_RST_BYTE;
      r1_ff <= `TSIE_RST_BYTE;
      r2_ff <= `TSIE_RST_BYTE;
      cmp_ff <= `TSIE_RST_BYTE;
      adres_ff <= 10'h000;
      pc_ff <= `TSIE_RST_PC;
      sp_ff <= `TSIE_RST_SP;
      roma_ff <= 12'h000;
      op_ff <= 10'h000;
      romq_ff <= 10'h000;
      cnt_ff <= 2'd0;
      busy_out <= 1'b0;
      skip_ff <= 1'b0;
      run_skip_ff <= 1'b0;
    end else begin
      if (wr_go) begin
        case (ofs)
          `TSIE_OFS_ACC: begin
            a_ff <= pwdata_in[3:0];
            b_ff <= pwdata_in[7:4];
            cy_ff <= pwdata_in[`TSIE_ACC_CY_BIT];
          end
          `TSIE_OFS_YD: begin
            y_ff <= pwdata_in[3:0];
            d_ff <= pwdata_in[6:4];
          end
          `TSIE_OFS_EXT: e_ff <= pwdata_in[7:0];
          `TSIE_OFS_TMR1: begin
            timer_one_out <= pwdata_in[7:0];
            r1_ff <= pwdata_in[15:8];
          end
          `TSIE_OFS_TMR2: begin
            timer_two_out <= pwdata_in[7:0];
            r2_ff <= pwdata_in[15:8];
          end
          `TSIE_OFS_ADC: begin
            adres_ff <= pwdata_in[9:0];
            q13_ff <= pwdata_in[`TSIE_ADC_MODE_BIT];
          end
          `TSIE_OFS_CMP: cmp_ff <= pwdata_in[7:0];
          `TSIE_OFS_CTL: begin
            i1_ff <= pwdata_in[3:0];
            k0_ff <= pwdata_in[7:4];
            k1_ff <= pwdata_in[11:8];
            k2_ff <= pwdata_in[15:12];
          end
          `TSIE_OFS_PCSP: if (!busy_out) pc_ff <= pwdata_in[11:0];
          `TSIE_OFS_ROMA: roma_ff <= pwdata_in[11:0];
          default: ;
        endcase
      end
      // issue: exec writes while busy are dropped
      if (start) begin
        op_ff <= pwdata_in[9:0];
        cnt_ff <= ncyc;
        busy_out <= 1'b1;
        run_skip_ff <= skip_ff; // [RULE_17]
        skip_ff <= 1'b0;
      end
      // table read staging over three cycles
      if (tick && busy_out && live && is_table) begin
        if (cnt_ff == 2'd3) begin
          sp_ff <= sp_ff + 3'd1; // [RULE_12]
        end else if (cnt_ff == 2'd2) begin
          pc_ff <= tbl_addr; // [RULE_11]
          romq_ff <= rom_mem[tbl_addr];
        end
      end
      if (tick && busy_out && cnt_ff != 2'd1) begin
        cnt_ff <= cnt_ff - 2'd1;
      end
      // commit; skipped words only advance the program counter
      if (last_cyc) begin
        busy_out <= 1'b0;
        pc_ff <= pc_ff + {10'h000, op_words}; // [RULE_17]
        if (live) begin
          skip_ff <= skip_new; // [RULE_01] [RULE_02]
          case (op_ff)
            `TSIE_OP_LOAD_T1: begin
              timer_one_out <= {b_ff, a_ff}; // [RULE_04]
              r1_ff <= {b_ff, a_ff};
            end
            `TSIE_OP_LOAD_T2: begin
              timer_two_out <= {b_ff, a_ff}; // [RULE_05]
              r2_ff <= {b_ff, a_ff};
            end
            `TSIE_OP_B_TO_A: a_ff <= b_ff; // [RULE_06]
            `TSIE_OP_RD_T1: begin
              b_ff <= timer_one_out[7:4]; // [RULE_07]
              a_ff <= timer_one_out[3:0];
            end
            `TSIE_OP_RD_T2: begin
              b_ff <= timer_two_out[7:4]; // [RULE_07]
              a_ff <= timer_two_out[3:0];
            end
            `TSIE_OP_RD_CONV: begin
              if (q13_ff) begin
                b_ff <= cmp_ff[7:4]; // [RULE_08]
                a_ff <= cmp_ff[3:0];
              end else begin
                b_ff <= adres_ff[9:6]; // [RULE_08]
                a_ff <= adres_ff[5:2];
              end
            end
            `TSIE_OP_WR_CMP: begin
              // conversion mode leaves the comparator untouched
              if (q13_ff) cmp_ff <= {b_ff, a_ff}; // [RULE_09]
            end
            `TSIE_OP_RD_EXT: begin
              b_ff <= e_ff[7:4]; // [RULE_10]
              a_ff <= e_ff[3:0];
            end
            `TSIE_OP_RD_PSEL: a_ff <= {1'b0, d_ff}; // [RULE_13]
            `TSIE_OP_RD_INT1: a_ff <= i1_ff; // [RULE_14]
            `TSIE_OP_RD_WK0: a_ff <= k0_ff; // [RULE_15]
            `TSIE_OP_RD_WK1: a_ff <= k1_ff; // [RULE_15]
            `TSIE_OP_RD_WK2: a_ff <= k2_ff; // [RULE_15]
            `TSIE_OP_RD_LOW: a_ff <= {adres_ff[1:0], 2'b00}; // [RULE_16]
            default: ;
          endcase
          if (is_table) begin
            b_ff <= romq_ff[7:4]; // [RULE_11]
            a_ff <= romq_ff[3:0];
            pc_ff <= stk_mem[sp_ff] + 12'h001; // [RULE_12]
            sp_ff <= sp_ff - 3'd1;
          end
        end
      end
    end
  end

endmodule

`default_nettype wire

// ---- tsie_cyc_div.v ----
`timescale 1ns/10ps
`default_nettype none

// ====================================================================
// instruction cycle divider: one-clock tick every DIV clocks while run
module tsie_cyc_div #(
  parameter DIV = 4
) (
  // clock and reset
  input wire clk_in,
  input wire nrst_in,
  // control
  input wire run_in,
  // tick
  output reg tick_out
);

  reg [7:0] cnt_ff;

  // restarts on each instruction so every cycle has equal length
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_ff <= 8'h00;
      tick_out <= 1'b0;
    end else if (!run_in) begin
      cnt_ff <= 8'h00;
      tick_out <= 1'b0;
    end else if (cnt_ff == DIV[7:0] - 8'h01) begin
      cnt_ff <= 8'h00;
      tick_out <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
      tick_out <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ---- tsie_defs.vh ----
`ifndef TSIE_DEFS_VH
`define TSIE_DEFS_VH

// ====================================================================
// apb register byte offsets
`define TSIE_OFS_EXEC 8'h00
`define TSIE_OFS_ACC 8'h04
`define TSIE_OFS_YD 8'h08
`define TSIE_OFS_EXT 8'h0C
`define TSIE_OFS_TMR1 8'h10
`define TSIE_OFS_TMR2 8'h14
`define TSIE_OFS_ADC 8'h18
`define TSIE_OFS_CMP 8'h1C
`define TSIE_OFS_CTL 8'h20
`define TSIE_OFS_PCSP 8'h24
`define TSIE_OFS_ROMA 8'h28
`define TSIE_OFS_ROMD 8'h2C

// ====================================================================
// field positions
`define TSIE_ACC_B_LSB 4
`define TSIE_ACC_CY_BIT 8
`define TSIE_YD_D_LSB 4
`define TSIE_TMR_RLD_LSB 8
`define TSIE_ADC_MODE_BIT 16
`define TSIE_CTL_K0_LSB 4
`define TSIE_CTL_K1_LSB 8
`define TSIE_CTL_K2_LSB 12
`define TSIE_PCSP_SP_LSB 16
`define TSIE_EXEC_BUSY_BIT 0
`define TSIE_EXEC_SKIP_BIT 1

// ====================================================================
// reset values
`define TSIE_RST_NIB 4'h0
`define TSIE_RST_BYTE 8'h00
`define TSIE_RST_PC 12'h000
`define TSIE_RST_SP 3'h7

// ====================================================================
// timing: core clocks per instruction cycle; number of port bits
`define TSIE_CYC_CLKS 4
`define TSIE_PORT_BITS 6

// ====================================================================
// instruction words
`define TSIE_OP_SKIP_CARRY 10'h02F
`define TSIE_OP_SKIP_PORT 10'h024
`define TSIE_OP_LOAD_T1 10'h230
`define TSIE_OP_LOAD_T2 10'h231
`define TSIE_OP_B_TO_A 10'h01E
`define TSIE_OP_RD_T1 10'h270
`define TSIE_OP_RD_T2 10'h271
`define TSIE_OP_RD_CONV 10'h279
`define TSIE_OP_WR_CMP 10'h239
`define TSIE_OP_RD_EXT 10'h02A
`define TSIE_OP_RD_PSEL 10'h051
`define TSIE_OP_RD_INT1 10'h253
`define TSIE_OP_RD_WK0 10'h256
`define TSIE_OP_RD_WK1 10'h259
`define TSIE_OP_RD_WK2 10'h25A
`define TSIE_OP_RD_LOW 10'h249
`define TSIE_OP_TABLE_HI 5'h04

`endif
